// ---- fan_speed_status_reporter_test.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fsr_map.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    mismatches++; $display("unexpected %s expected %h seen %h", n, e, g); \
    end end
module fan_speed_status_reporter_test;
    import fsr_pkg::*;
    logic         sys_clk = 1'b0;
    logic         rst = 1'b1;
    logic [7:0]   reg_addr = 8'h00;
    logic [31:0]  reg_wdata = 32'h0;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic [1:0]   drv_speed = 2'h0;
    logic [1:0]   man_speed = 2'h0;
    logic         auto_on = 1'b0;
    fsr_mode_in_t mode_in = '0;
    logic         lim_on = 1'b0;
    logic [1:0]   lim_lo = 2'h0;
    logic [1:0]   lim_hi = 2'h3;
    logic [7:0]   ctl_value = 8'h00;
    logic [3:0]   ack_delay = 4'h0;
    logic [31:0]  reg_rdata;
    logic [31:0]  rd_val;
    logic         bus_req, tx_ack, tx_valid, fan_on, auto_stat, irq;
    logic [2:0]   bus_req_obj, stat_speed_bit;
    logic [7:0]   stat_speed_byte, stat_mode, c;
    logic [1:0]   auto_speed, old, nxt, cur;
    fsr_tx_t      tx;
    fsr_tx_t      got;
    logic [7:0]   thr [1:3];
    logic [4:0]   hyst;
    integer       seed = 32'h38bc;
    int           mismatches = 0;
    int           samples_checked = 0;

    always #4 sys_clk = ~sys_clk;

    fsr_top fsr_top_i (
        .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .drv_speed, .man_speed, .auto_on, .mode_in,
        .lim_on, .lim_lo, .lim_hi, .ctl_value, .bus_req, .bus_req_obj,
        .tx_ack, .tx_valid, .tx, .stat_speed_bit, .stat_speed_byte,
        .stat_mode, .fan_on, .auto_stat, .auto_speed, .irq
    );
    fsr_bus_model fsr_bus_model_i (
        .sys_clk, .rst, .tx_valid, .tx, .ack_delay, .tx_ack, .bus_req,
        .bus_req_obj
    );

    // ==========================================
    // Helpers
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        tick(1);
        reg_wr <= 1'b0;
        tick(1);
    endtask
    task automatic rd(logic [7:0] a);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        tick(1);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
        tick(1);
    endtask
    task automatic flush;
        tick(20);
        fsr_bus_model_i.log_q.delete();
    endtask
    task automatic expect_tel(logic [2:0] o, logic [7:0] d, logic r);
        int n;
        n = 0;
        while (fsr_bus_model_i.log_q.size() == 0 && n < 40) begin
            tick(1);
            n++;
        end
        if (fsr_bus_model_i.log_q.size() == 0) begin
            mismatches++;
            $display("unexpected telegram expected %h seen none", {o, d, r});
            print_verdict();
        end else begin
            got = fsr_bus_model_i.log_q.pop_front();
            `CHK("telegram", {o, d, r}, got)
        end
    endtask
    task automatic no_tel;
        tick(12);
        `CHK("telegram count", 0, fsr_bus_model_i.log_q.size())
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    function automatic logic [2:0] onehot(logic [1:0] s);
        return 3'((4'h1 << s) >> 1);
    endfunction
    function automatic logic [1:0] raw_speed(logic [7:0] v);
        if (v > thr[3]) return 2'd3;
        if (v > thr[2]) return 2'd2;
        return v > thr[1] ? 2'd1 : 2'd0;
    endfunction
    function automatic logic [1:0] auto_next(logic [1:0] s, logic [7:0] v);
        int lo;
        int hi;
        lo = s == 2'd0 ? -1000 : int'(thr[s]) - int'(hyst);
        hi = s == 2'd3 ? 1000 : int'(thr[s + 2'd1]) + int'(hyst);
        if (v == 8'h00) return 2'd0;
        if (int'(v) > hi || int'(v) < lo) return raw_speed(v);
        return s;
    endfunction

    // ==========================================
    // Main sequence
    initial begin
        tick(10);
        rst <= 1'b0;
        tick(1);
        rd(`FSR_OFF_POL);
        `CHK("pol reset", 32'h155, rd_val)
        rd(`FSR_OFF_THR);
        `CHK("thr reset", 32'h05461e0a, rd_val)
        rd(8'h18);
        `CHK("unmapped read", 32'h0, rd_val)
        $display("test reset finished");
        wr(`FSR_OFF_CFG, 32'h0b);
        flush();
        for (int i = 0; i < 8; i++) begin
            ack_delay <= 4'($random(seed));
            old = drv_speed;
            nxt = old + 2'(1 + {$random(seed)} % 3);
            drv_speed <= nxt;
            for (int k = 0; k < 3; k++)
                if (old == 2'(k + 1) || nxt == 2'(k + 1))
                    expect_tel(3'(k), 8'(nxt == 2'(k + 1)), 1'b0);
            expect_tel(3'h3, 8'(nxt), 1'b0);
            if ((old != 0) != (nxt != 0))
                expect_tel(3'h5, 8'(nxt != 0), 1'b0);
            `CHK("speed bits", onehot(nxt), stat_speed_bit)
            `CHK("fan on", nxt != 0, fan_on)
        end
        $display("test on change finished");
        wr(`FSR_OFF_CFG, 32'h02);
        for (int p = 0; p < 4; p++) begin
            wr(`FSR_OFF_POL, 32'h151 | 32'(p) << 2);
            flush();
            nxt = drv_speed + 2'd1;
            drv_speed <= nxt;
            if (p[0]) expect_tel(3'h3, 8'(nxt), 1'b0);
            else no_tel();
            rd(`FSR_OFF_IRQ_STAT);
            fsr_bus_model_i.read_req(3'h3);
            if (p[1]) expect_tel(3'h3, 8'(nxt), 1'b1);
            else no_tel();
            rd(`FSR_OFF_IRQ_STAT);
            `CHK("refused", !p[1], rd_val[2])
        end
        $display("test policies finished");
        wr(`FSR_OFF_CFG, 32'hc3);
        drv_speed <= 2'd1;
        man_speed <= 2'd3;
        lim_on    <= 1'b1;
        lim_hi    <= 2'd2;
        tick(4);
        `CHK("required byte", 8'd2, stat_speed_byte)
        `CHK("required bits", 3'b010, stat_speed_bit)
        rd(`FSR_OFF_STAT);
        `CHK("stat speeds", 4'h9, rd_val[3:0])
        man_speed <= 2'd1;
        lim_lo    <= 2'd2;
        lim_hi    <= 2'd3;
        tick(4);
        `CHK("lower clip", 8'd2, stat_speed_byte)
        $display("test required finished");
        wr(`FSR_OFF_CFG, 32'h34);
        for (int i = 0; i < 6; i++) begin
            mode_in <= 7'($random(seed));
            auto_on <= 1'($random(seed));
            tick(4);
            `CHK("mode", {mode_in.limit, mode_in.forced, auto_on, mode_in.cool,
                mode_in.heat}, stat_mode)
            `CHK("auto status", auto_on, auto_stat)
        end
        wr(`FSR_OFF_CFG, 32'h14);
        auto_on <= 1'b1;
        tick(4);
        `CHK("auto hidden", 1'b0, auto_stat)
        $display("test mode finished");
        wr(`FSR_OFF_CFG, 32'h20);
        thr[1] = 8'd10;
        thr[2] = 8'd20;
        thr[3] = 8'd30;
        hyst   = 5'd15;
        wr(`FSR_OFF_THR, {3'h0, hyst, thr[3], thr[2], thr[1]});
        cur = 2'd0;
        for (int i = 0; i < 20; i++) begin
            c = i < 5 ? 8'(32'h000e3228 >> (i * 8)) + 8'(i == 0) * 8'd26 : 8'(
                {$random(seed)} % 101);
            ctl_value <= c;
            cur = auto_next(cur, c);
            tick(4);
            `CHK("auto speed", cur, auto_speed)
        end
        $display("test automatic finished");
        flush();
        wr(`FSR_OFF_IRQ_MASK, 32'h1);
        rd(`FSR_OFF_IRQ_STAT);
        tick(3);
        `CHK("irq idle", 1'b0, irq)
        drv_speed <= drv_speed + 2'd1;
        tick(4);
        `CHK("irq raised", 1'b1, irq)
        rd(`FSR_OFF_IRQ_STAT);
        `CHK("irq status", 1'b1, rd_val[0])
        tick(3);
        `CHK("irq cleared", 1'b0, irq)
        wr(`FSR_OFF_IRQ_MASK, 32'h0);
        drv_speed <= drv_speed + 2'd1;
        tick(4);
        `CHK("irq masked", 1'b0, irq)
        $display("test interrupt finished");
        print_verdict();
    end
endmodule
`default_nettype wire

// ---- fsr_auto_speed.sv ----
`timescale 1ns/10ps
`default_nettype none
module fsr_auto_speed (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [7:0] ctl,
    input  wire logic [7:0] thr1,
    input  wire logic [7:0] thr2,
    input  wire logic [7:0] thr3,
    input  wire logic [4:0] hyst,
    output logic      [1:0] speed
);
    logic [1:0] raw;
    logic [7:0] thr_up;
    logic [7:0] thr_dn;
    logic       trig;

    // Ascending walk, each step only after the lower one passed
    always_comb begin
        raw = 2'd0;
        if (ctl > thr1) raw = 2'd1; // R12
        if (raw == 2'd1 && ctl > thr2) raw = 2'd2; // R12
        if (raw == 2'd2 && ctl > thr3) raw = 2'd3; // R12
    end

    always_comb begin
        case (speed)
            2'd0: begin thr_up = thr1; thr_dn = 8'h00; end
            2'd1: begin thr_up = thr2; thr_dn = thr1; end
            2'd2: begin thr_up = thr3; thr_dn = thr2; end
            default: begin thr_up = 8'hff; thr_dn = thr3; end
        endcase
        trig = (speed != 2'd3 &&
                {1'b0, ctl} > {1'b0, thr_up} + {4'h0, hyst}) || // R14
               (speed != 2'd0 &&
                {1'b0, ctl} + {4'h0, hyst} < {1'b0, thr_dn}); // R14
    end

    always_ff @(posedge sys_clk) begin
        if (rst)
            speed <= 2'd0;
        else if (ctl == 8'h00)
            speed <= 2'd0; // R15
        else if (trig)
            speed <= raw; // R14
    end

    AST_ZERO_OFF: assert property (@(posedge sys_clk) disable iff (rst) // R15
        ctl == 8'h00 |=> speed == 2'd0)
        else $error("zero control value did not stop the fan");
    AST_HOLD_NO_TRIG: assert property (@(posedge sys_clk) disable iff (rst) // R14
        (ctl != 8'h00 && !trig) |=> $stable(speed))
        else $error("speed moved inside the hysteresis band");
endmodule
`default_nettype wire

// ---- fsr_bus_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module fsr_bus_model (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             tx_valid,
    input  wire fsr_pkg::fsr_tx_t tx,
    input  wire logic [3:0]       ack_delay,
    output logic                  tx_ack,
    output logic                  bus_req,
    output logic [2:0]            bus_req_obj
);
    import fsr_pkg::*;
    fsr_tx_t    log_q[$];
    logic [3:0] wait_cnt;
    initial begin
        bus_req     = 1'b0;
        bus_req_obj = 3'h7;
    end
    // ==========================================
    // Read request from a subscriber
    task automatic read_req(logic [2:0] o);
        bus_req     <= 1'b1;
        bus_req_obj <= o;
        @(posedge sys_clk);
        bus_req     <= 1'b0;
        bus_req_obj <= ~o;
    endtask
    // ==========================================
    // Telegram intake, at once or after a stall
    always @(posedge sys_clk) begin
        if (rst || !tx_valid) begin
            tx_ack   <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (tx_ack) begin
            log_q.push_back(tx);
            tx_ack   <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (wait_cnt >= ack_delay) begin
            tx_ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ---- fsr_map.svh ----
// What this block does
// R1 - With per-speed status on, three one-bit outputs show whether speed 1, 2 or 3 is reported.
// R2 - Each speed status picks current or required speed, current being the default.
// R3 - The current speed is the speed the fan output drives now, stepping speeds included.
// R4 - The required speed is the final target, clipped by active limitations.
// R5 - Each status has a send policy: update only, on change, on request, or both; on change is default.
// R6 - Under update only the value is kept current but never sent spontaneously.
// R7 - The one-byte speed status carries the numeric speed, current or required, with its own policy.
// R8 - The one-byte mode status flags heating, cooling, automatic, forced and four limitations.
// R9 - The one-bit fan status shows that the fan runs.
// R10 - The automatic status bit is 1 in automatic operation and 0 otherwise.
// R11 - The automatic status exists only when automatic operation is enabled for the fan.
// R12 - Automatic mode checks thresholds in ascending order: off-1, then 1-2, then 2-3.
// R13 - Software must keep the three thresholds in strictly ascending order.
// R14 - A transition fires only past threshold plus or minus hysteresis; the new speed uses raw thresholds.
// R15 - A control value of zero always forces speed zero.
// R16 - A read request to an output allowing requests is answered with its present value.
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH
`define FSR_OFF_CFG      8'h00
`define FSR_OFF_POL      8'h04
`define FSR_OFF_THR      8'h08
`define FSR_OFF_STAT     8'h0c
`define FSR_OFF_IRQ_STAT 8'h10
`define FSR_OFF_IRQ_MASK 8'h14
`define FSR_CFG_EN_BITS  0
`define FSR_CFG_EN_BYTE  1
`define FSR_CFG_EN_MODE  2
`define FSR_CFG_EN_ONOFF 3
`define FSR_CFG_EN_AUTO  4
`define FSR_CFG_AUTO_OK  5
`define FSR_CFG_REQ_BITS 6
`define FSR_CFG_REQ_BYTE 7
`define FSR_CFG_RST      8'h00
`define FSR_POL_RST      10'h155
`define FSR_THR1_RST     8'h0a
`define FSR_THR2_RST     8'h1e
`define FSR_THR3_RST     8'h46
`define FSR_HYST_RST     5'h05
`define FSR_OBJS         7
`endif

// ---- fsr_pkg.sv ----
package fsr_pkg;
    typedef enum logic [1:0] {
        FSR_POL_UPDATE,
        FSR_POL_CHANGE,
        FSR_POL_REQUEST,
        FSR_POL_BOTH
    } fsr_pol_t;
    typedef struct packed {
        logic [2:0] obj;
        logic [7:0] data;
        logic       resp;
    } fsr_tx_t;
    typedef struct packed {
        logic       heat;
        logic       cool;
        logic       forced;
        logic [3:0] limit;
    } fsr_mode_in_t;
endpackage

// ---- fsr_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fsr_map.svh"
module fsr_top (
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [31:0]          reg_rdata,
    input  wire logic [1:0]           drv_speed,
    input  wire logic [1:0]           man_speed,
    input  wire logic                 auto_on,
    input  wire fsr_pkg::fsr_mode_in_t mode_in,
    input  wire logic                 lim_on,
    input  wire logic [1:0]           lim_lo,
    input  wire logic [1:0]           lim_hi,
    input  wire logic [7:0]           ctl_value,
    input  wire logic                 bus_req,
    input  wire logic [2:0]           bus_req_obj,
    input  wire logic                 tx_ack,
    output logic                      tx_valid,
    output fsr_pkg::fsr_tx_t          tx,
    output logic      [2:0]           stat_speed_bit,
    output logic      [7:0]           stat_speed_byte,
    output logic      [7:0]           stat_mode,
    output logic                      fan_on,
    output logic                      auto_stat,
    output logic      [1:0]           auto_speed,
    output logic                      irq
);
    import fsr_pkg::*;

    localparam int N = `FSR_OBJS;

    logic [7:0]     cfg;
    logic [9:0]     pol;
    logic [7:0]     thr1;
    logic [7:0]     thr2;
    logic [7:0]     thr3;
    logic [4:0]     hyst;
    logic [2:0]     irq_stat;
    logic [2:0]     irq_mask;
    logic [1:0]     req_speed;
    logic [1:0]     next_req_speed;
    logic [1:0]     target;
    logic [1:0]     bits_src;
    logic [1:0]     byte_src;
    logic [7:0]     val      [N];
    logic [7:0]     next_val [N];
    logic [8*N-1:0] vals;
    logic [N-1:0]   en;
    logic [N-1:0]   chg;
    logic [N-1:0]   req;
    logic [N-1:0]   req_ok;
    logic [2*N-1:0] pol_obj;
    logic [1:0]     prev_drv;
    logic [2:0]     irq_evt;
    logic           auto_ok;
    logic           auto_act;

    // ==========================================================
    // Register port
    // ==========================================================
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfg  <= `FSR_CFG_RST;
            pol  <= `FSR_POL_RST; // R5
            thr1 <= `FSR_THR1_RST;
            thr2 <= `FSR_THR2_RST;
            thr3 <= `FSR_THR3_RST;
            hyst <= `FSR_HYST_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `FSR_OFF_CFG: cfg <= reg_wdata[7:0];
                `FSR_OFF_POL: pol <= reg_wdata[9:0];
                `FSR_OFF_THR: begin
                    thr1 <= reg_wdata[7:0];
                    thr2 <= reg_wdata[15:8];
                    thr3 <= reg_wdata[23:16];
                    hyst <= reg_wdata[28:24];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst)
            irq_mask <= 3'h0;
        else if (reg_wr && reg_addr == `FSR_OFF_IRQ_MASK)
            irq_mask <= reg_wdata[2:0];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                `FSR_OFF_CFG:      reg_rdata <= {24'h0, cfg};
                `FSR_OFF_POL:      reg_rdata <= {22'h0, pol};
                `FSR_OFF_THR:      reg_rdata <= {3'h0, hyst, thr3, thr2,
                                                 thr1};
                `FSR_OFF_STAT:     reg_rdata <= {16'h0, stat_mode, 2'h0,
                                                 auto_speed, req_speed,
                                                 drv_speed};
                `FSR_OFF_IRQ_STAT: reg_rdata <= {29'h0, irq_stat};
                `FSR_OFF_IRQ_MASK: reg_rdata <= {29'h0, irq_mask};
                default:           reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // ==========================================================
    // Interrupts: speed change, telegram sent, request refused
    // ==========================================================
    always_comb begin
        irq_evt[0] = drv_speed != prev_drv;
        irq_evt[1] = tx_valid && tx_ack;
        irq_evt[2] = bus_req && 32'(bus_req_obj) < N && !req_ok[bus_req_obj];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prev_drv <= 2'd0;
            irq_stat <= 3'h0;
            irq      <= 1'b0;
        end else begin
            prev_drv <= drv_speed;
            if (reg_rd && reg_addr == `FSR_OFF_IRQ_STAT)
                irq_stat <= irq_evt;
            else
                irq_stat <= irq_stat | irq_evt;
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ==========================================================
    // Automatic speed and required speed
    // ==========================================================
    fsr_auto_speed u_auto (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ctl     (ctl_value),
        .thr1    (thr1),
        .thr2    (thr2),
        .thr3    (thr3),
        .hyst    (hyst),
        .speed   (auto_speed)
    );

    assign auto_ok  = cfg[`FSR_CFG_AUTO_OK];
    assign auto_act = auto_ok && auto_on;

    always_comb begin
        target = auto_act ? auto_speed : man_speed;
        next_req_speed = target;
        if (lim_on && target > lim_hi) next_req_speed = lim_hi; // R4
        if (lim_on && target < lim_lo) next_req_speed = lim_lo; // R4
    end

    always_ff @(posedge sys_clk) begin
        if (rst)
            req_speed <= 2'd0;
        else
            req_speed <= next_req_speed; // R4
    end

    // ==========================================================
    // Status values, one per output object
    // ==========================================================
    assign bits_src = cfg[`FSR_CFG_REQ_BITS] ? req_speed : drv_speed; // R2 R3
    assign byte_src = cfg[`FSR_CFG_REQ_BYTE] ? req_speed : drv_speed; // R3 R7

    always_comb begin
        for (int k = 0; k < 3; k++)
            next_val[k] = {7'h0, bits_src == 2'(k + 1)}; // R1
        next_val[3] = {6'h0, byte_src}; // R7
        next_val[4] = {mode_in.limit, mode_in.forced, auto_act,
                       mode_in.cool, mode_in.heat}; // R8
        next_val[5] = {7'h0, drv_speed != 2'd0}; // R9
        next_val[6] = {7'h0, auto_act}; // R10
    end

    // Object enables; automatic status needs automatic operation
    assign en = {cfg[`FSR_CFG_EN_AUTO] & auto_ok, // R11
                 cfg[`FSR_CFG_EN_ONOFF], cfg[`FSR_CFG_EN_MODE],
                 cfg[`FSR_CFG_EN_BYTE], {3{cfg[`FSR_CFG_EN_BITS]}}};
    assign pol_obj = {pol[9:8], pol[7:6], pol[5:4], pol[3:2],
                      pol[1:0], pol[1:0], pol[1:0]}; // R5

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_val
            assign chg[g] = next_val[g] != val[g];
            assign req[g] = bus_req && bus_req_obj == 3'(g);
            assign vals[8*g+:8] = val[g];
            // Value kept current whatever the send policy
            always_ff @(posedge sys_clk) begin
                if (rst)
                    val[g] <= 8'h00;
                else
                    val[g] <= next_val[g]; // R6
            end
        end
    endgenerate

    fsr_tx_arb #(
        .N (N)
    ) u_arb (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .en       (en),
        .chg      (chg),
        .req      (req),
        .pol      (pol_obj),
        .vals     (vals),
        .tx_ack   (tx_ack),
        .tx_valid (tx_valid),
        .tx       (tx),
        .req_ok   (req_ok)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stat_speed_bit  <= 3'h0;
            stat_speed_byte <= 8'h00;
            stat_mode       <= 8'h00;
            fan_on          <= 1'b0;
            auto_stat       <= 1'b0;
        end else begin
            stat_speed_bit  <= {next_val[2][0], next_val[1][0],
                                next_val[0][0]}; // R1
            stat_speed_byte <= next_val[3]; // R7
            stat_mode       <= next_val[4]; // R8
            fan_on          <= next_val[5][0]; // R9
            auto_stat       <= next_val[6][0] & en[6]; // R10 R11
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    AST_SPEED_BITS: assert property (@(posedge sys_clk) disable iff (rst) // R1
        ##1 $onehot0(stat_speed_bit) &&
        (stat_speed_bit == 3'h0) == ($past(bits_src) == 2'd0))
        else $error("speed bits disagree with reported speed");
    AST_CUR_SPEED: assert property (@(posedge sys_clk) disable iff (rst) // R3
        !cfg[`FSR_CFG_REQ_BYTE] && $stable(cfg) |=>
        stat_speed_byte == {6'h0, $past(drv_speed)})
        else $error("speed byte not the driven speed");
    AST_LIMIT_CLIP: assert property (@(posedge sys_clk) disable iff (rst) // R4
        lim_on && lim_lo <= lim_hi |=>
        req_speed <= $past(lim_hi) && req_speed >= $past(lim_lo))
        else $error("required speed outside limitation");
    AST_FAN_ON: assert property (@(posedge sys_clk) disable iff (rst) // R9
        drv_speed != 2'd0 |=> fan_on)
        else $error("fan running but status off");
    AST_AUTO_BIT: assert property (@(posedge sys_clk) disable iff (rst) // R10
        en[6] && auto_act |=> auto_stat ##1 1'b1)
        else $error("automatic status not set");
    AST_AUTO_ABSENT: assert property (@(posedge sys_clk) disable iff (rst) // R11
        !auto_ok |-> !(tx_valid && tx.obj == 3'd6 && $rose(tx_valid)))
        else $error("absent automatic status was sent");
    AST_MODE_BYTE: assert property (@(posedge sys_clk) disable iff (rst) // R8
        mode_in.heat && $stable(mode_in) |=> stat_mode[0])
        else $error("heating flag missing from mode byte");
    AST_RST_POLICY: assert property (@(posedge sys_clk) // R5
        rst |=> pol == `FSR_POL_RST)
        else $error("send policy reset value wrong");
endmodule
`default_nettype wire

// ---- fsr_tx_arb.sv ----
`timescale 1ns/10ps
`default_nettype none
module fsr_tx_arb
    import fsr_pkg::*;
#(
    parameter int N = 7
) (
    input  wire logic           sys_clk,
    input  wire logic           rst,
    input  wire logic [N-1:0]   en,
    input  wire logic [N-1:0]   chg,
    input  wire logic [N-1:0]   req,
    input  wire logic [2*N-1:0] pol,
    input  wire logic [8*N-1:0] vals,
    input  wire logic           tx_ack,
    output logic                tx_valid,
    output fsr_pkg::fsr_tx_t    tx,
    output logic [N-1:0]        req_ok
);
    typedef enum logic {FSR_ARB_IDLE, FSR_ARB_SEND} fsr_arb_t;
    fsr_arb_t       state;
    logic [N-1:0]   pend_chg;
    logic [N-1:0]   pend_req;
    logic [N-1:0]   grant;
    logic [2:0]     pick;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_obj
            logic on_chg;
            logic on_req;
            assign on_chg = en[g] && pol[2*g+:2] inside {FSR_POL_CHANGE,
                                                         FSR_POL_BOTH};
            assign on_req = en[g] && pol[2*g+:2] inside {FSR_POL_REQUEST,
                                                         FSR_POL_BOTH};
            assign req_ok[g] = on_req;
            // Set beats the grant clear in the same cycle
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    pend_chg[g] <= 1'b0;
                    pend_req[g] <= 1'b0;
                end else begin
                    pend_chg[g] <= (pend_chg[g] & ~grant[g] & on_chg)
                                   | (chg[g] & on_chg); // R5 R6
                    pend_req[g] <= (pend_req[g] & ~grant[g] & on_req)
                                   | (req[g] & on_req); // R16
                end
            end
            AST_UPD_SILENT: assert property (@(posedge sys_clk) // R6
                disable iff (rst)
                pol[2*g+:2] == FSR_POL_UPDATE |=> !pend_chg[g] && !pend_req[g])
                else $error("update-only output queued a telegram");
            AST_REQ_QUEUED: assert property (@(posedge sys_clk) // R16
                disable iff (rst)
                req[g] && on_req |=> pend_req[g])
                else $error("read request not queued");
        end
    endgenerate

    always_comb begin
        pick  = 3'd0;
        grant = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend_chg[i] || pend_req[i]) pick = 3'(i);
        end
        if (state == FSR_ARB_IDLE && (|pend_chg || |pend_req))
            grant[pick] = 1'b1;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state    <= FSR_ARB_IDLE;
            tx_valid <= 1'b0;
            tx       <= '0;
        end else begin
            case (state)
                FSR_ARB_IDLE: begin
                    if (|grant) begin
                        tx_valid <= 1'b1;
                        tx.obj   <= pick;
                        tx.data  <= vals[8*pick+:8]; // R16
                        tx.resp  <= pend_req[pick];
                        state    <= FSR_ARB_SEND;
                    end
                end
                FSR_ARB_SEND: begin
                    if (tx_ack) begin
                        tx_valid <= 1'b0;
                        state    <= FSR_ARB_IDLE;
                    end
                end
                default: state <= FSR_ARB_IDLE;
            endcase
        end
    end

    sequence s_granted;
        state == FSR_ARB_IDLE && |grant;
    endsequence
    sequence s_sent;
        tx_valid && tx_ack;
    endsequence
    AST_GRANT_SEND: assert property (@(posedge sys_clk) disable iff (rst) // R16
        s_granted |=> tx_valid && tx.data == $past(vals[8*pick+:8]))
        else $error("granted value not presented");
    AST_HOLD_TILL_ACK: assert property (@(posedge sys_clk) disable iff (rst)
        tx_valid && !tx_ack |=> tx_valid && $stable(tx))
        else $error("telegram dropped before acknowledge");
    AST_ACK_RELEASE: assert property (@(posedge sys_clk) disable iff (rst) // R16
        s_sent |=> !tx_valid)
        else $error("telegram still offered after acknowledge");
endmodule
`default_nettype wire
